// File: pkg/wdtit_pkg.sv
package wdtit_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_COUNT_WR = 8'ha8;
    localparam logic [7:0] IDX_COUNT_RD = 8'ha9;
    localparam logic [7:0] IDX_RSTCS_WR = 8'haa;
    localparam logic [7:0] IDX_RSTCS_RD = 8'hab;
    localparam logic [7:0] IDX_TCS = 8'hac;
    localparam logic [7:0] IDX_IRQ_STAT = 8'had;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hae;

    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] TCS_RESET = 8'h18;
    localparam logic [7:0] RSTCS_RESET = 8'h3f;

    // Timer control/status fields
    localparam int TCS_OVERFLOW_BIT = 7;
    localparam int TCS_MODE_BIT = 6;
    localparam int TCS_RUN_BIT = 5;
    localparam logic [7:0] TCS_UNUSED_MASK = 8'h18;
    // Reset control/status fields
    localparam int RSTCS_FLAG_BIT = 7;
    localparam int RSTCS_PINEN_BIT = 6;
    localparam logic [7:0] RSTCS_UNUSED_MASK = 8'h3f;

    // Interrupt status bits
    localparam int IRQ_BITS = 2;
    localparam int IRQ_INTERVAL_BIT = 0;
    localparam int IRQ_WATCHDOG_BIT = 1;

    // Prescaler: tick when the low N bits of a free counter are all ones
    localparam int PRESC_W = 12;
    typedef logic [PRESC_W-1:0] wdtit_presc_t;
    localparam wdtit_presc_t PRESC_MASK [8] = '{
        12'h001, 12'h01f, 12'h03f, 12'h07f,
        12'h0ff, 12'h1ff, 12'h7ff, 12'hfff
    };

    // Watchdog reset pulse width
    localparam int RESET_PULSE_NS = 64;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic overflow_flag;
        logic watchdog_or_interval_select;
        logic timer_run_enable;
        logic [1:0] unused;
        logic [2:0] prescale_select;
    } wdtit_tcs_t;

    typedef struct packed {
        logic watchdog_reset_flag;
        logic reset_pin_drive_enable;
        logic [5:0] unused;
    } wdtit_rstcs_t;

    typedef enum logic [1:0] {
        WDTIT_IDLE = 2'b01,
        WDTIT_PULSE = 2'b10
    } wdtit_state_t;
endpackage

// File: rtl/wdtit_top.sv
`timescale 1ns/1ps
`default_nettype none

module wdtit_top #(
    parameter int ADDR_W = 12,
    parameter int PULSE_CYCLES = wdtit_pkg::RESET_PULSE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wdt_reset_out,
    output logic reset_pin_out
);

    wdtit_pkg::wdtit_tcs_t tcs_reg;
    wdtit_pkg::wdtit_tcs_t tcs_next;
    wdtit_pkg::wdtit_rstcs_t rstcs_reg;
    wdtit_pkg::wdtit_rstcs_t rstcs_next;
    wdtit_pkg::wdtit_presc_t presc_reg;
    wdtit_pkg::wdtit_state_t state_reg;
    wdtit_pkg::wdtit_state_t state_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [15:0] pulse_cnt_reg;
    logic [15:0] pulse_cnt_next;
    logic [wdtit_pkg::IRQ_BITS-1:0] irq_stat_reg;
    logic [wdtit_pkg::IRQ_BITS-1:0] irq_mask_reg;
    logic overflow_seen_reg;
    logic reset_flag_seen_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic rst_out_reg;
    logic rst_pin_reg;

    // Bus decode
    wire [7:0] idx = paddr[9:2];
    wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
    wire setup = psel && !penable;
    wire access = psel && penable && pready_reg;
    wire wr_acc = access && pwrite && !pslverr_reg;
    wire rd_acc = access && !pwrite && !pslverr_reg;
    wire lane0 = pstrb[0];
    wire wr_count = wr_acc && lane0 && (idx == wdtit_pkg::IDX_COUNT_WR);
    wire wr_rstcs = wr_acc && lane0 && (idx == wdtit_pkg::IDX_RSTCS_WR);
    wire wr_tcs = wr_acc && lane0 && (idx == wdtit_pkg::IDX_TCS);
    wire wr_istat = wr_acc && lane0 && (idx == wdtit_pkg::IDX_IRQ_STAT);
    wire wr_imask = wr_acc && lane0 && (idx == wdtit_pkg::IDX_IRQ_MASK);
    wire rd_tcs = rd_acc && (idx == wdtit_pkg::IDX_TCS);
    wire rd_rstcs = rd_acc && (idx == wdtit_pkg::IDX_RSTCS_RD);

    wire rd_hit = addr_ok && ((idx == wdtit_pkg::IDX_COUNT_RD)
        || (idx == wdtit_pkg::IDX_RSTCS_RD) || (idx == wdtit_pkg::IDX_TCS)
        || (idx == wdtit_pkg::IDX_IRQ_STAT) || (idx == wdtit_pkg::IDX_IRQ_MASK));
    wire wr_hit = addr_ok && ((idx == wdtit_pkg::IDX_COUNT_WR)
        || (idx == wdtit_pkg::IDX_RSTCS_WR) || (idx == wdtit_pkg::IDX_TCS)
        || (idx == wdtit_pkg::IDX_IRQ_STAT) || (idx == wdtit_pkg::IDX_IRQ_MASK));
    wire hit = pwrite ? wr_hit : rd_hit;

    // Prescaler and counter
    wire running = tcs_reg.timer_run_enable;
    wire [wdtit_pkg::PRESC_W-1:0] sel_mask =
        wdtit_pkg::PRESC_MASK[tcs_reg.prescale_select];
    wire tick = running && ((presc_reg & sel_mask) == sel_mask);
    wire overflow = tick && (count_reg == wdtit_pkg::COUNT_MAX) && !wr_count;
    wire wd_mode = tcs_reg.watchdog_or_interval_select;
    wire ev_interval = overflow && !wd_mode;
    wire ev_watchdog = overflow && wd_mode;

    // Read data, reserved bits of control registers read one
    wire [7:0] tcs_rd = tcs_reg | wdtit_pkg::TCS_UNUSED_MASK;
    wire [7:0] rstcs_rd = rstcs_reg | wdtit_pkg::RSTCS_UNUSED_MASK;
    wire [7:0] rd_mux =
        (idx == wdtit_pkg::IDX_COUNT_RD) ? count_reg :
        (idx == wdtit_pkg::IDX_RSTCS_RD) ? rstcs_rd :
        (idx == wdtit_pkg::IDX_TCS) ? tcs_rd :
        (idx == wdtit_pkg::IDX_IRQ_STAT) ? {6'h00, irq_stat_reg} :
        (idx == wdtit_pkg::IDX_IRQ_MASK) ? {6'h00, irq_mask_reg} : 8'h00;

    // Counter next value
    always_comb
    begin
        count_next = count_reg;
        if (!running)
        begin
            count_next = wdtit_pkg::COUNT_RESET;
        end
        else if (wr_count)
        begin
            count_next = pwdata[7:0];
        end
        else if (tick)
        begin
            count_next = count_reg + 8'h01;
        end
    end

    // Timer control/status next value
    always_comb
    begin
        tcs_next = tcs_reg;
        if (wr_tcs)
        begin
            tcs_next.watchdog_or_interval_select = pwdata[wdtit_pkg::TCS_MODE_BIT];
            tcs_next.timer_run_enable = pwdata[wdtit_pkg::TCS_RUN_BIT];
            tcs_next.prescale_select = pwdata[2:0];
            // Only a zero after a read of one clears; a one does not clear but disarms the read
            if (!pwdata[wdtit_pkg::TCS_OVERFLOW_BIT] && overflow_seen_reg)
            begin
                tcs_next.overflow_flag = 1'b0;
            end
        end
        tcs_next.unused = 2'b11;
        if (overflow)
        begin
            tcs_next.overflow_flag = 1'b1;
        end
    end

    // Reset control/status next value
    always_comb
    begin
        rstcs_next = rstcs_reg;
        if (wr_rstcs)
        begin
            rstcs_next.reset_pin_drive_enable = pwdata[wdtit_pkg::RSTCS_PINEN_BIT];
            if (!pwdata[wdtit_pkg::RSTCS_FLAG_BIT] && reset_flag_seen_reg)
            begin
                rstcs_next.watchdog_reset_flag = 1'b0;
            end
        end
        rstcs_next.unused = 6'h3f;
        if (ev_watchdog)
        begin
            rstcs_next.watchdog_reset_flag = 1'b1;
        end
    end

    // Watchdog reset pulse sequencer
    always_comb
    begin
        state_next = state_reg;
        pulse_cnt_next = pulse_cnt_reg;
        case (state_reg)
            wdtit_pkg::WDTIT_IDLE:
            begin
                if (ev_watchdog)
                begin
                    state_next = wdtit_pkg::WDTIT_PULSE;
                    pulse_cnt_next = 16'(PULSE_CYCLES - 1);
                end
            end
            wdtit_pkg::WDTIT_PULSE:
            begin
                if (pulse_cnt_reg == 16'h0000)
                begin
                    state_next = wdtit_pkg::WDTIT_IDLE;
                end
                else
                begin
                    pulse_cnt_next = pulse_cnt_reg - 16'h0001;
                end
            end
            default:
            begin
                state_next = wdtit_pkg::WDTIT_IDLE;
                pulse_cnt_next = 16'h0000;
            end
        endcase
    end

    wire pulse_active = (state_next == wdtit_pkg::WDTIT_PULSE);

    // Sticky events, set wins over a write-one clear
    wire [wdtit_pkg::IRQ_BITS-1:0] ev_vec = {ev_watchdog, ev_interval};
    wire [wdtit_pkg::IRQ_BITS-1:0] istat_next =
        (irq_stat_reg & ~(wr_istat ? pwdata[wdtit_pkg::IRQ_BITS-1:0] : '0)) | ev_vec;

    // The read-one half of each clear sequence; a later write consumes it
    wire overflow_seen_next = rd_tcs ? tcs_reg.overflow_flag
        : (wr_tcs ? 1'b0 : overflow_seen_reg);
    wire reset_flag_seen_next = rd_rstcs ? rstcs_reg.watchdog_reset_flag
        : (wr_rstcs ? 1'b0 : reset_flag_seen_reg);

    // Prescaler restarts whenever the timer is stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_reg <= '0;
        end
        else
        begin
            presc_reg <= running ? presc_reg + 12'h001 : '0;
        end
    end

    // Asynchronous reset stands for the external reset input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_reg <= wdtit_pkg::COUNT_RESET;
            tcs_reg <= wdtit_pkg::TCS_RESET;
            rstcs_reg <= wdtit_pkg::RSTCS_RESET;
            overflow_seen_reg <= 1'b0;
            reset_flag_seen_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            tcs_reg <= tcs_next;
            rstcs_reg <= rstcs_next;
            overflow_seen_reg <= overflow_seen_next;
            reset_flag_seen_reg <= reset_flag_seen_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= wdtit_pkg::WDTIT_IDLE;
            pulse_cnt_reg <= 16'h0000;
            rst_out_reg <= 1'b0;
            rst_pin_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            pulse_cnt_reg <= pulse_cnt_next;
            rst_out_reg <= pulse_active;
            rst_pin_reg <= pulse_active && rstcs_next.reset_pin_drive_enable;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= istat_next;
            if (wr_imask)
            begin
                irq_mask_reg <= pwdata[wdtit_pkg::IRQ_BITS-1:0];
            end
            irq_reg <= |(istat_next & (wr_imask
                ? pwdata[wdtit_pkg::IRQ_BITS-1:0] : irq_mask_reg));
        end
    end

    // No wait state: answer captured in setup, given in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= setup;
            pslverr_reg <= setup && !hit;
            prdata_reg <= (setup && !pwrite && rd_hit) ? {24'h000000, rd_mux} : 32'h0000_0000;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign wdt_reset_out = rst_out_reg;
    assign reset_pin_out = rst_pin_reg;

endmodule // wdtit_top

`default_nettype wire

// File: dv/wdtit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wdtit_checker #(
    parameter int ADDR_W = 12,
    parameter int PULSE_CYCLES = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic wdt_reset_out,
    input wire logic reset_pin_out
);
    wire logic setup = psel && !penable;
    wire logic [7:0] idx = paddr[9:2];
    wire logic bad_dir = pwrite ? (idx == 8'ha9 || idx == 8'hab) : (idx == 8'ha8 || idx == 8'haa);
    logic [15:0] hi_cnt;
    // Pulse length is a parameter, so a counter instead of a repetition
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hi_cnt <= 16'h0;
        else
            hi_cnt <= wdt_reset_out ? hi_cnt + 16'h1 : 16'h0;
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (setup |=> pready) else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready) else $error("answer held too long");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("stray answer");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
    a_rdata_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper data set");
    a_wrong_dir_err: assert property (setup && bad_dir |=> pready && pslverr)
        else $error("wrong direction accepted");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without answer");
    a_pin_gated: assert property (reset_pin_out |-> wdt_reset_out)
        else $error("pin pulse without reset");
    a_pulse_width: assert property ($fell(wdt_reset_out) |-> hi_cnt == 16'(PULSE_CYCLES))
        else $error("reset pulse width wrong");
    a_pulse_bound: assert property (hi_cnt <= 16'(PULSE_CYCLES)) else $error("pulse too long");
    c_wdt: cover property ($rose(wdt_reset_out));
    c_pin: cover property ($rose(reset_pin_out));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pready && pslverr);
endmodule // wdtit_checker
bind wdtit_top wdtit_checker #(.ADDR_W(ADDR_W), .PULSE_CYCLES(PULSE_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .wdt_reset_out(wdt_reset_out), .reset_pin_out(reset_pin_out)
);
`default_nettype wire

// File: dv/tb_watchdog_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_interval_timer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wdt_out, pin_out, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] q;
    logic wdt_q = 1'b0;
    logic [3:0] strb_v = 4'hf;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int wdt_rises = 0;
    int pin_rises = 0;

    wdtit_top #(.ADDR_W(12), .PULSE_CYCLES(2)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .wdt_reset_out(wdt_out), .reset_pin_out(pin_out)
    );

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Both pulses rise on the same edge, so one previous value serves
    always @(posedge pclk)
    begin
        cycles++;
        wdt_q <= wdt_out;
        if (wdt_out === 1'b1 && wdt_q !== 1'b1)
            wdt_rises++;
        if (pin_out === 1'b1 && wdt_q !== 1'b1)
            pin_rises++;
        if (cycles == 40000)
        begin
            fails++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= strb_v;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk("pready", 8'h01, {7'h0, pready});
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
        apb(1'b0, idx, 8'h00);
        chk(name, exp, q);
    endtask

    task automatic t_reset_vals();
        rd(8'ha9, 8'h00, "count");
        rd(8'hac, 8'h18, "timer ctrl");
        rd(8'hab, 8'h3f, "reset ctrl");
        rd(8'had, 8'h00, "irq status");
    endtask

    task automatic t_access();
        logic [8:0] bad [5] = '{9'h1a9, 9'h1ab, 9'h0a8, 9'h0aa, 9'h010};
        foreach (bad[i])
        begin
            apb(bad[i][8], bad[i][7:0], 8'h00);
            chk("pslverr", 8'h01, {7'h0, e});
        end
        wr(8'hac, 8'h00);
        rd(8'hac, 8'h18, "timer ctrl unused");
        wr(8'haa, 8'h00);
        rd(8'hab, 8'h3f, "reset ctrl unused");
        wr(8'ha8, 8'h55);
        rd(8'ha9, 8'h00, "count held");
        // Low byte lane off: the write must leave the mask alone
        strb_v = 4'h0;
        wr(8'hae, 8'h03);
        strb_v = 4'hf;
        rd(8'hae, 8'h00, "mask lane off");
    endtask

    task automatic t_prescale();
        int div [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
        for (int s = 0; s < 8; s++)
        begin
            wr(8'hac, 8'h20 | 8'(s));
            repeat (3 * div[s]) @(posedge pclk);
            apb(1'b0, 8'ha9, 8'h00);
            chk("count ticks", 8'h01, {7'h0, q == 8'h03 || q == 8'h04});
            wr(8'hac, 8'h18);
            rd(8'ha9, 8'h00, "count stopped");
        end
    endtask

    task automatic t_interval();
        int n;
        wdt_rises = 0;
        wr(8'hac, 8'h20);
        wr(8'ha8, 8'hfe);
        n = 0;
        do
        begin
            apb(1'b0, 8'hac, 8'h00);
            n++;
        end
        while (q[7] !== 1'b1 && n < 10);
        chk("overflow", 8'hb8, q);
        rd(8'had, 8'h01, "irq status");
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(8'hae, 8'h01);
        @(posedge pclk);
        chk("irq", 8'h01, {7'h0, irq});
        // Write of one disarms, so the next zero must not clear
        wr(8'hac, 8'h98);
        wr(8'hac, 8'h18);
        rd(8'hac, 8'h98, "flag kept");
        wr(8'hac, 8'h18);
        rd(8'hac, 8'h18, "flag cleared");
        wr(8'had, 8'h01);
        @(posedge pclk);
        chk("irq cleared", 8'h00, {7'h0, irq});
        chk("no reset", 8'h00, 8'(wdt_rises));
    endtask

    task automatic t_watchdog(input logic [7:0] pin_en, input logic ext_reset);
        wdt_rises = 0;
        pin_rises = 0;
        wr(8'haa, pin_en);
        wr(8'hae, 8'h02);
        wr(8'hac, 8'h60);
        wr(8'ha8, 8'hfe);
        for (int n = 0; n < 100 && wdt_rises == 0; n++) @(posedge pclk);
        wr(8'hac, 8'h18);
        chk("reset pulses", 8'h01, 8'(wdt_rises));
        chk("pin pulses", {7'h0, pin_en[6]}, 8'(pin_rises));
        chk("irq watchdog", 8'h01, {7'h0, irq});
        rd(8'had, 8'h02, "irq status");
        wr(8'had, 8'h02);
        rd(8'hab, 8'hbf | pin_en, "reset flag");
        if (ext_reset)
        begin
            presetn <= 1'b0;
            repeat (4) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            rd(8'hab, 8'h3f, "flag after reset");
        end
        else
        begin
            wr(8'haa, 8'h80 | pin_en);
            rd(8'hab, 8'hbf | pin_en, "flag kept");
            wr(8'haa, pin_en);
            rd(8'hab, 8'h3f | pin_en, "flag cleared");
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals();
        t_access();
        t_prescale();
        t_interval();
        t_watchdog(8'h40, 1'b0);
        t_watchdog(8'h00, 1'b1);
        results();
    end
endmodule // tb_watchdog_interval_timer
`default_nettype wire
